// *** core/flash_pin_mode.v ***
// flash_pin_mode.v: pin roles, pause, hardware reset and serial shifting of a serial flash
// assumes link pins are asynchronous to CLK_IN and the serial clock is much slower than it
`default_nettype none
`include "pin_mode_map.vh"
module flash_pin_mode #(
  parameter ADDR_W = 24
) (
  // clock and reset
  input  wire              CLK_IN,
  input  wire              RESET_IN,
  // link pins (output enable low while driving)
  input  wire              SCK_IN,
  input  wire              CS_N_IN,
  input  wire              HW_RESET_N_IN,
  input  wire              DATA_LANE_0_IN,
  output wire              DATA_LANE_0_OUT,
  output wire              DATA_LANE_0_OE_N_OUT,
  input  wire              DATA_LANE_1_IN,
  output wire              DATA_LANE_1_OUT,
  output wire              DATA_LANE_1_OE_N_OUT,
  input  wire              DATA_LANE_2_IN,
  output wire              DATA_LANE_2_OUT,
  output wire              DATA_LANE_2_OE_N_OUT,
  input  wire              DATA_LANE_3_IN,
  output wire              DATA_LANE_3_OUT,
  output wire              DATA_LANE_3_OE_N_OUT,
  // configuration
  input  wire              STATUS_WR_IN,
  input  wire [7:0]        STATUS_WDATA_IN,
  input  wire              FUNC_RESET_BIT_IN,
  input  wire              RESET_PIN_FITTED_IN,
  input  wire              PIN_ROLE_SELECT_BIT_IN,
  input  wire              FOUR_LANE_COMMAND_MODE_IN,
  input  wire              QUAD_DATA_PHASE_IN,
  input  wire              DRIVE_PHASE_IN,
  // user data
  input  wire [7:0]        TX_BYTE_IN,
  output wire              TX_TAKE_OUT,
  output reg  [7:0]        RX_BYTE_OUT,
  output reg               RX_VALID_OUT,
  output reg               SELECT_START_OUT,
  // status
  output wire [7:0]        STATUS_OUT,
  output wire              QUAD_LANE_ENABLE_OUT,
  output wire              PAUSED_OUT,
  output wire              IN_RESET_OUT,
  output wire              SELECTED_OUT,
  // address region lookup
  input  wire [ADDR_W-1:0] REGION_ADDR_IN,
  output wire [ADDR_W-`SECTOR_ADDR_BITS-1:0] SECTOR_OUT,
  output wire [ADDR_W-`BLK32_ADDR_BITS-1:0]  BLOCK32_OUT,
  output wire [ADDR_W-`BLK64_ADDR_BITS-1:0]  BLOCK64_OUT
);
  // synchronised pins
  wire       sck_s;
  wire       cs_n_s;
  wire       rst_pin_s;
  wire [3:0] lane_s;

  // configuration and framing state
  reg  [7:0] status_q;
  reg        sck_prev_q;
  reg        armed_q;
  reg        cs_prev_q;

  // shift state
  reg  [7:0] rx_sh_q;
  reg  [2:0] rx_cnt_q;
  reg  [7:0] tx_sh_q;
  reg  [2:0] tx_cnt_q;
  reg  [3:0] out_q;
  reg        take_q;

  // role decode and edge strobes
  wire       quad_lane_enable;
  reg        reset_pin_role;
  reg        pause_role;
  reg        hw_reset_act;
  wire       paused;
  wire       selected;
  wire       multi;
  wire       rise;
  wire       fall;
  wire [2:0] bits_step;
  wire       drive_io;

  // reset values match each pin's idle level, so no false edge follows reset
  pin_sync #(.RESET_VAL(1'b0)) u_sck (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (SCK_IN),
    .pin_out (sck_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_cs (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (CS_N_IN),
    .pin_out (cs_n_s)
  );

  // an open reset pin reads high through its pull-up
  pin_sync #(.RESET_VAL(1'b1)) u_rst (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (HW_RESET_N_IN),
    .pin_out (rst_pin_s)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_l0 (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (DATA_LANE_0_IN),
    .pin_out (lane_s[0])
  );

  pin_sync #(.RESET_VAL(1'b0)) u_l1 (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (DATA_LANE_1_IN),
    .pin_out (lane_s[1])
  );

  pin_sync #(.RESET_VAL(1'b0)) u_l2 (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (DATA_LANE_2_IN),
    .pin_out (lane_s[2])
  );

  // the fourth pin idles high, as pause and reset are both active low
  pin_sync #(.RESET_VAL(1'b1)) u_l3 (
    .clk_in  (CLK_IN),
    .reset_in(RESET_IN),
    .pin_in  (DATA_LANE_3_IN),
    .pin_out (lane_s[3])
  );

  addr_region #(.ADDR_W(ADDR_W)) u_region (
    .addr_in   (REGION_ADDR_IN),
    .sector_out(SECTOR_OUT),
    .blk32_out (BLOCK32_OUT),
    .blk64_out (BLOCK64_OUT)
  );

  // status register; only the quad lane enable bit matters here
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      status_q <= `STATUS_RESET;
    end else if (STATUS_WR_IN) begin
      status_q <= STATUS_WDATA_IN;
    end
  end
  assign quad_lane_enable = status_q[`QE_BIT_POS];

  assign multi = FOUR_LANE_COMMAND_MODE_IN | (quad_lane_enable & QUAD_DATA_PHASE_IN);

  // pin roles of the fourth pin; quad enable or four-lane mode makes it pure data
  always @* begin
    reset_pin_role = 1'b0;
    pause_role     = 1'b0;
    hw_reset_act   = 1'b0;
    if (RESET_PIN_FITTED_IN) begin
      // fitted reset pin: fourth pin is pause whatever the role bit says
      reset_pin_role = (FUNC_RESET_BIT_IN == `RESET_FUNC_BIT);
      pause_role     = !quad_lane_enable && !FOUR_LANE_COMMAND_MODE_IN;
      hw_reset_act   = reset_pin_role & ~rst_pin_s;
    end else if (!quad_lane_enable && !FOUR_LANE_COMMAND_MODE_IN) begin
      if (PIN_ROLE_SELECT_BIT_IN) begin
        // this variant borrows the fourth pin as an active-low reset
        hw_reset_act = ~lane_s[3];
      end else begin
        pause_role = 1'b1;
      end
    end
  end

  // a reset pin that is asserted looks like a deselect to the shift logic
  assign selected       = ~cs_n_s & ~hw_reset_act;
  assign paused         = pause_role & ~lane_s[3] & selected;

  assign rise      = sck_s & ~sck_prev_q;
  assign fall      = ~sck_s & sck_prev_q;
  assign bits_step = multi ? 3'd4 : 3'd1;

  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
      armed_q    <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
      // first instruction only after a select falling edge
      if (cs_prev_q & ~cs_n_s) begin
        armed_q <= 1'b1;
      end
    end
  end

  // receive: rising edge sampling, msb first; pause holds the partial byte
  always @(posedge CLK_IN) begin
    if (RESET_IN || !selected) begin
      rx_sh_q          <= 8'h00;
      rx_cnt_q         <= 3'd0;
      RX_BYTE_OUT      <= 8'h00;
      RX_VALID_OUT     <= 1'b0;
      SELECT_START_OUT <= 1'b0;
    end else begin
      RX_VALID_OUT     <= 1'b0;
      // pulse on the select falling edge itself, which is also what arms
      SELECT_START_OUT <= cs_prev_q & ~cs_n_s;
      if (rise && !paused && armed_q && !DRIVE_PHASE_IN) begin
        if (multi) begin
          rx_sh_q <= {rx_sh_q[3:0], lane_s};
        end else begin
          rx_sh_q <= {rx_sh_q[6:0], lane_s[0]};
        end
        rx_cnt_q <= rx_cnt_q + bits_step;
        if (rx_cnt_q + bits_step == 3'd0) begin
          RX_BYTE_OUT  <= multi ? {rx_sh_q[3:0], lane_s} : {rx_sh_q[6:0], lane_s[0]};
          RX_VALID_OUT <= 1'b1;
        end
      end
    end
  end

  // transmit: launch on falling edge, msb first; a byte is loaded at its first bit
  // limitation: the byte must be on TX_BYTE_IN before that fall, there is no buffer
  always @(posedge CLK_IN) begin
    if (RESET_IN || !selected) begin
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 3'd0;
      out_q    <= 4'h0;
      take_q   <= 1'b0;
    end else begin
      take_q <= 1'b0;
      if (fall && !paused && DRIVE_PHASE_IN) begin
        if (tx_cnt_q == 3'd0) begin
          take_q <= 1'b1;
          if (multi) begin
            out_q   <= TX_BYTE_IN[7:4];
            tx_sh_q <= {TX_BYTE_IN[3:0], 4'h0};
          end else begin
            out_q   <= {2'b00, TX_BYTE_IN[7], 1'b0};
            tx_sh_q <= {TX_BYTE_IN[6:0], 1'b0};
          end
        end else if (multi) begin
          out_q   <= tx_sh_q[7:4];
          tx_sh_q <= {tx_sh_q[3:0], 4'h0};
        end else begin
          out_q   <= {2'b00, tx_sh_q[7], 1'b0};
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
        tx_cnt_q <= tx_cnt_q + bits_step;
      end
    end
  end

  // output enables (low = driving); reset and pause float everything
  assign drive_io = selected & DRIVE_PHASE_IN & ~paused;
  assign DATA_LANE_0_OUT      = out_q[0];
  assign DATA_LANE_1_OUT      = out_q[1];
  assign DATA_LANE_2_OUT      = out_q[2];
  assign DATA_LANE_3_OUT      = out_q[3];
  assign DATA_LANE_0_OE_N_OUT = ~(drive_io & multi);
  assign DATA_LANE_1_OE_N_OUT = ~drive_io;
  assign DATA_LANE_2_OE_N_OUT = ~(drive_io & multi);
  assign DATA_LANE_3_OE_N_OUT = ~(drive_io & multi);

  assign TX_TAKE_OUT          = take_q;
  assign STATUS_OUT           = status_q;
  assign QUAD_LANE_ENABLE_OUT = quad_lane_enable;
  assign PAUSED_OUT           = paused;
  assign IN_RESET_OUT         = hw_reset_act;
  assign SELECTED_OUT         = selected;
endmodule
`default_nettype wire

// *** core/pin_mode_map.vh ***
// pin_mode_map.vh: constants for the serial flash pin-role and bus-mode logic
// assumes inclusion by bare name from the core/ design files
`ifndef PIN_MODE_MAP_VH
`define PIN_MODE_MAP_VH
`define QE_BIT_POS        3'd6
`define STATUS_RESET      8'h00
`define RESET_FUNC_BIT    1'b0
`define SECTOR_ADDR_BITS  12
`define BLK32_ADDR_BITS   15
`define BLK64_ADDR_BITS   16
`define SYNC_STAGES       2
`endif

// *** core/pin_sync.v ***
// pin_sync.v: two flip-flop synchroniser for one asynchronous pin
// assumes the pin is unrelated to CLK_IN
`default_nettype none
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk_in,
  input  wire reset_in,
  input  wire pin_in,
  output wire pin_out
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
  assign pin_out = sync_q;
endmodule
`default_nettype wire

// *** core/addr_region.v ***
// addr_region.v: sector and block numbers of a byte address
// assumes a flat byte address with uniform sector and block sizes
`default_nettype none
`include "pin_mode_map.vh"
module addr_region #(
  parameter ADDR_W = 24
) (
  input  wire [ADDR_W-1:0]                     addr_in,
  output wire [ADDR_W-`SECTOR_ADDR_BITS-1:0]   sector_out,
  output wire [ADDR_W-`BLK32_ADDR_BITS-1:0]    blk32_out,
  output wire [ADDR_W-`BLK64_ADDR_BITS-1:0]    blk64_out
);
  assign sector_out = addr_in[ADDR_W-1:`SECTOR_ADDR_BITS];
  assign blk32_out  = addr_in[ADDR_W-1:`BLK32_ADDR_BITS];
  assign blk64_out  = addr_in[ADDR_W-1:`BLK64_ADDR_BITS];
endmodule
`default_nettype wire

// *** testbench/flash_pin_mode_checker.sv ***
// flash_pin_mode_checker.sv: port-level assertions for the flash pin-mode block
// assumes it is bound into flash_pin_mode and sees only that module's ports
`default_nettype none
module flash_pin_mode_checker (
  // clock and reset
  input wire logic       CLK_IN,
  input wire logic       RESET_IN,
  // link pins and configuration
  input wire logic       CS_N_IN,
  input wire logic       HW_RESET_N_IN,
  input wire logic       RESET_PIN_FITTED_IN,
  input wire logic       STATUS_WR_IN,
  input wire logic [7:0] STATUS_WDATA_IN,
  // observed outputs
  input wire logic [7:0] STATUS_OUT,
  input wire logic       QUAD_LANE_ENABLE_OUT,
  input wire logic       PAUSED_OUT,
  input wire logic       IN_RESET_OUT,
  input wire logic       SELECTED_OUT,
  input wire logic       SELECT_START_OUT,
  input wire logic       RX_VALID_OUT,
  input wire logic       DATA_LANE_0_OE_N_OUT,
  input wire logic       DATA_LANE_1_OE_N_OUT,
  input wire logic       DATA_LANE_2_OE_N_OUT,
  input wire logic       DATA_LANE_3_OE_N_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire all_float = &{DATA_LANE_0_OE_N_OUT, DATA_LANE_1_OE_N_OUT,
                     DATA_LANE_2_OE_N_OUT, DATA_LANE_3_OE_N_OUT};
  quad_no_pause_a: assert property (QUAD_LANE_ENABLE_OUT |-> !PAUSED_OUT)
    else $error("pause seen with quad lanes on");
  fitted_no_reset_a: assert property (
    (RESET_PIN_FITTED_IN && HW_RESET_N_IN)[*4] |-> !IN_RESET_OUT)
    else $error("fourth pin acted as reset");
  pause_hold_a: assert property (PAUSED_OUT[*2] |-> !RX_VALID_OUT)
    else $error("byte completed while paused");
  pause_float_a: assert property (PAUSED_OUT && !CS_N_IN |-> DATA_LANE_1_OE_N_OUT)
    else $error("output driven while paused");
  hw_float_a: assert property (IN_RESET_OUT |-> all_float)
    else $error("lane driven in reset");
  desel_float_a: assert property (!SELECTED_OUT |-> all_float)
    else $error("lane driven while deselected");
  desel_drop_a: assert property (CS_N_IN[*5] |-> !SELECTED_OUT)
    else $error("still selected after select rose");
  select_start_a: assert property (
    $fell(CS_N_IN) && HW_RESET_N_IN |-> ##[1:5] SELECT_START_OUT)
    else $error("no select start pulse");
  status_wr_a: assert property (STATUS_WR_IN |=> STATUS_OUT == $past(STATUS_WDATA_IN)
    && QUAD_LANE_ENABLE_OUT == STATUS_OUT[6])
    else $error("status write not taken");
  cover property (RX_VALID_OUT);
  cover property (PAUSED_OUT && !CS_N_IN);
  cover property (IN_RESET_OUT);
endmodule
bind flash_pin_mode flash_pin_mode_checker u_flash_pin_mode_checker (.*);
`default_nettype wire

// *** testbench/spi_master_model.sv ***
// spi_master_model.sv: behavioural serial master for the flash pins
// assumes the bench resolves the shared lanes from the device's enables
`default_nettype none
module spi_master_model (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  output logic      pause_n_out,
  input wire logic  miso_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol = 1'b0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    pause_n_out = 1'b1;
  end
  // park the clock before select moves, so a polarity change is never seen selected
  task automatic sel(input logic on);
    sck_out = cpol;
    #100 cs_n_out = !on;
    #200;
  endtask
  // msb first; at bit pause_at the pause is held while the clock still toggles
  task automatic xfer(input logic [7:0] tx, input int pause_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      mosi_out = tx[i];
      if (i == pause_at) begin
        pause_n_out = 1'b0;
        repeat (2) begin
          #80 sck_out = 1'b1;
          #80 sck_out = 1'b0;
        end
        #80 pause_n_out = 1'b1;
      end
      #80 sck_out = 1'b1;
      rx[i] = miso_in;
      #80;
    end
    sck_out = cpol;
    mosi_out = ~mosi_out;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top.sv: self-checking bench for the flash pin-role and serial logic
// assumes the design, its checker and the master model compile first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_IN = 1'b0, RESET_IN = 1'b1, HW_RESET_N_IN = 1'b1, STATUS_WR_IN = 1'b0;
  logic FUNC_RESET_BIT_IN = 1'b0, RESET_PIN_FITTED_IN = 1'b1, PIN_ROLE_SELECT_BIT_IN = 1'b0;
  logic FOUR_LANE_COMMAND_MODE_IN = 1'b0, QUAD_DATA_PHASE_IN = 1'b0, DRIVE_PHASE_IN = 1'b0;
  logic [7:0]  STATUS_WDATA_IN = 8'h00, TX_BYTE_IN = 8'h00, RX_BYTE_OUT, STATUS_OUT, rx;
  logic [23:0] REGION_ADDR_IN = 24'h000000;
  logic [11:0] SECTOR_OUT;
  logic [8:0]  BLOCK32_OUT;
  logic [7:0]  BLOCK64_OUT;
  logic SCK_IN, CS_N_IN, mosi, pause_n, TX_TAKE_OUT, RX_VALID_OUT, SELECT_START_OUT;
  logic QUAD_LANE_ENABLE_OUT, PAUSED_OUT, IN_RESET_OUT, SELECTED_OUT;
  logic DATA_LANE_0_OUT, DATA_LANE_1_OUT, DATA_LANE_2_OUT, DATA_LANE_3_OUT;
  logic DATA_LANE_0_OE_N_OUT, DATA_LANE_1_OE_N_OUT, DATA_LANE_2_OE_N_OUT, DATA_LANE_3_OE_N_OUT;
  // a released lane 1 shows the inverse of its last level; lane 0 shows mosi; the protect lane is pulled up
  wire DATA_LANE_0_IN = DATA_LANE_0_OE_N_OUT ? mosi : DATA_LANE_0_OUT;
  wire DATA_LANE_1_IN = DATA_LANE_1_OE_N_OUT ? ~DATA_LANE_1_OUT : DATA_LANE_1_OUT;
  wire DATA_LANE_2_IN = DATA_LANE_2_OE_N_OUT | DATA_LANE_2_OUT;
  wire DATA_LANE_3_IN = DATA_LANE_3_OE_N_OUT ? pause_n : DATA_LANE_3_OUT;
  wire [3:0] oe_n = {DATA_LANE_3_OE_N_OUT, DATA_LANE_2_OE_N_OUT,
                     DATA_LANE_1_OE_N_OUT, DATA_LANE_0_OE_N_OUT};
  int err_count = 0;
  int n_checks = 0;
  int n_take = 0, n_rx = 0;
  always @(posedge CLK_IN) begin
    if (TX_TAKE_OUT === 1'b1) n_take <= n_take + 1;
    if (RX_VALID_OUT === 1'b1) n_rx <= n_rx + 1;
  end
  flash_pin_mode u_flash_pin_mode (.*);
  spi_master_model u_spi_master_model (.sck_out(SCK_IN), .cs_n_out(CS_N_IN),
    .mosi_out(mosi), .pause_n_out(pause_n), .miso_in(DATA_LANE_1_IN));
  initial forever #5 CLK_IN = ~CLK_IN;
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_status(input logic [7:0] v);
    @(posedge CLK_IN) STATUS_WR_IN <= 1'b1;
    STATUS_WDATA_IN <= v;
    @(posedge CLK_IN) STATUS_WR_IN <= 1'b0;
    cyc(2);
    #1;
  endtask
  task automatic pin_level(input logic p);
    u_spi_master_model.pause_n_out = p;
    cyc(6);
    #1;
  endtask
  initial begin
    cyc(4);
    RESET_IN <= 1'b0;
    cyc(4);
    #1 check(STATUS_OUT, 8'h00);
    wr_status(8'h40);
    check(QUAD_LANE_ENABLE_OUT, 1'b1);
    u_spi_master_model.sel(1'b1);
    pin_level(1'b0);
    check(PAUSED_OUT, 1'b0);
    pin_level(1'b1);
    wr_status(8'h00);
    $display("test quad lane done");
    @(posedge CLK_IN) PIN_ROLE_SELECT_BIT_IN <= 1'b1;
    u_spi_master_model.xfer(8'hA5, 8, rx);
    cyc(6);
    #1 check(RX_BYTE_OUT, 8'hA5);
    u_spi_master_model.xfer(8'h3C, 4, rx);
    cyc(6);
    #1 check(RX_BYTE_OUT, 8'h3C);
    check(n_rx, 2);
    pin_level(1'b0);
    check({PAUSED_OUT, IN_RESET_OUT}, 2'b10);
    check(DATA_LANE_1_OE_N_OUT, 1'b1);
    pin_level(1'b1);
    $display("test receive and pause done");
    u_spi_master_model.sel(1'b0);
    check({SELECTED_OUT, oe_n}, 5'h0F);
    u_spi_master_model.cpol = 1'b1;
    @(posedge CLK_IN) DRIVE_PHASE_IN <= 1'b1;
    TX_BYTE_IN <= 8'hC6;
    u_spi_master_model.sel(1'b1);
    u_spi_master_model.xfer(8'h00, 8, rx);
    check(rx, 8'hC6);
    $display("test mode 3 read done");
    @(posedge CLK_IN) HW_RESET_N_IN <= 1'b0; // no internal write is under way here
    cyc(6);
    #1 check({IN_RESET_OUT, oe_n}, 5'h1F);
    @(posedge CLK_IN) HW_RESET_N_IN <= 1'b1;
    cyc(6);
    #1 check(IN_RESET_OUT, 1'b0);
    @(posedge CLK_IN) FUNC_RESET_BIT_IN <= 1'b1;
    HW_RESET_N_IN <= 1'b0;
    cyc(6);
    #1 check(IN_RESET_OUT, 1'b0);
    @(posedge CLK_IN) HW_RESET_N_IN <= 1'b1;
    $display("test hardware reset done");
    @(posedge CLK_IN) FOUR_LANE_COMMAND_MODE_IN <= 1'b1;
    TX_BYTE_IN <= 8'h5A;
    cyc(4);
    #1 check(oe_n, 4'h0);
    u_spi_master_model.xfer(8'h00, 8, rx);
    check(rx, 8'h55);
    check({DATA_LANE_3_OUT, DATA_LANE_2_OUT, DATA_LANE_1_OUT, DATA_LANE_0_OUT}, 4'hA);
    cyc(2);
    check(n_take, 5);
    $display("test four lane read done");
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK_IN) REGION_ADDR_IN <= k ? 24'h1F0000 : 24'h1EFFFF;
      #1 check(SECTOR_OUT, REGION_ADDR_IN[23:12]);
      check({BLOCK32_OUT, BLOCK64_OUT}, {REGION_ADDR_IN[23:15], REGION_ADDR_IN[23:16]});
    end
    $display("test address regions done");
    close_out();
  end
  initial begin
    #300us;
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
